// ==== dlf_regs_top.sv ====
// limit and fast-transient configuration registers of a triple buck regulator
//
// Functional notes
// - ch2 ceiling write below code is discarded
// - ch2 floor write above code is discarded
// - ch3 ceiling write below code is ignored
// - ch3 floor write above code is ignored
// - ceiling bits 7:4, ref+192mV-12mV/step
// - floor bits 3:0, ref-190.5mV+12mV/step
// - ch3 limits at 0xDE, reset zero
// - transient config at 0xDF, reset 0x3F
// - sensitivities ch3 5:4, ch2 3:2, ch1 1:0
// - 00 off, 01/10/11 window and gain
// - pin disable voids sensitivities, still read/write
// - output code is 408mV plus 1.5mV/step
// - code outside limits flagged not allowed
`timescale 1ns/1ps
`default_nettype none
`include "dlf_regs.svh"
module dlf_regs_top
    import dlf_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire dlf_req_t req_i, // decoded register access
    input wire logic [7:0] ch2_output_code_i, // present channel 2 code
    input wire logic [7:0] ch3_output_code_i, // present channel 3 code
    input wire logic transient_config_pin_i, // high disables fast transient
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_rejected_o,
    output logic [5:0] ft_effective_o,
    output logic [1:0] code_ok_o
);
    dlf_state_t st; // registered state
    dlf_state_t next_st; // next state
    logic [7:0] code [2]; // per-channel present code
    logic [7:0] cur_lim [2]; // per-channel stored limits
    logic [7:0] lim_addr [2]; // per-channel register offset
    logic [1:0] up_ok; // candidate ceiling accepted
    logic [1:0] lo_ok; // candidate floor accepted
    logic [1:0] in_rng; // present code within limits
    logic [7:0] merged [2]; // limit value after checks
    logic [1:0] hit; // write aimed at channel register

    assign code[0] = ch2_output_code_i;
    assign code[1] = ch3_output_code_i;
    assign cur_lim[0] = st.ch2_lim;
    assign cur_lim[1] = st.ch3_lim;
    assign lim_addr[0] = `DLF_CH2_LIM_ADDR;
    assign lim_addr[1] = `DLF_CH3_LIM_ADDR;

    // one checker per limited channel
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            dlf_limit_check u_chk (
                .code_i(code[g]),
                .cur_lim_i(cur_lim[g]),
                .new_lim_i(req_i.data),
                .upper_ok_o(up_ok[g]),
                .lower_ok_o(lo_ok[g]),
                .in_range_o(in_rng[g])
            );
            // each field kept or taken on its own check
            assign hit[g] = req_i.wr && (req_i.addr == lim_addr[g]);
            assign merged[g] = {up_ok[g] ? req_i.data[7:4] : cur_lim[g][7:4],
                                lo_ok[g] ? req_i.data[3:0] : cur_lim[g][3:0]};
        end
    endgenerate

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.rd_valid = req_i.rd;
        next_st.wr_rejected = 1'b0;
        // limit register writes
        if (hit[0]) begin
            next_st.ch2_lim = merged[0];
            next_st.wr_rejected = !(up_ok[0] && lo_ok[0]);
        end
        if (hit[1]) begin
            next_st.ch3_lim = merged[1];
            next_st.wr_rejected = !(up_ok[1] && lo_ok[1]);
        end
        // reserved bits 7:6 dropped
        if (req_i.wr && req_i.addr == `DLF_FAST_TRANSIENT_CONFIG_ADDR) begin
            next_st.fast_transient_config = req_i.data[5:0];
        end
        // read mux, unmapped reads give zero
        if (req_i.rd) begin
            case (req_i.addr)
                `DLF_CH2_LIM_ADDR: begin
                    next_st.rd_data = st.ch2_lim;
                end
                `DLF_CH3_LIM_ADDR: begin
                    next_st.rd_data = st.ch3_lim;
                end
                `DLF_FAST_TRANSIENT_CONFIG_ADDR: begin
                    next_st.rd_data = {2'b00, st.fast_transient_config};
                end
                default: begin
                    next_st.rd_data = 8'h00;
                end
            endcase
        end
        // sensitivities only reach regulation while the pin allows
        next_st.ft_effective = transient_config_pin_i ? 6'h00 : st.fast_transient_config;
        next_st.code_ok = in_rng;
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.ch2_lim <= `DLF_CH2_LIM_RST;
            st.ch3_lim <= `DLF_CH3_LIM_RST;
            st.fast_transient_config <= `DLF_FAST_TRANSIENT_CONFIG_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data_o = st.rd_data;
    assign rd_valid_o = st.rd_valid;
    assign wr_rejected_o = st.wr_rejected;
    assign ft_effective_o = st.ft_effective;
    assign code_ok_o = st.code_ok;

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_ch2_upper_keep;
        hit[0] && !up_ok[0] |=> st.ch2_lim[7:4] == $past(st.ch2_lim[7:4]) && wr_rejected_o;
    endproperty
    a_ch2_upper_keep: assert property (p_ch2_upper_keep) else $error("ch2 ceiling not kept");

    property p_ch2_lower_keep;
        hit[0] && !lo_ok[0] |=> st.ch2_lim[3:0] == $past(st.ch2_lim[3:0]) && wr_rejected_o;
    endproperty
    a_ch2_lower_keep: assert property (p_ch2_lower_keep) else $error("ch2 floor not kept");

    property p_ch3_upper_keep;
        hit[1] && !up_ok[1] |=> st.ch3_lim[7:4] == $past(st.ch3_lim[7:4]);
    endproperty
    a_ch3_upper_keep: assert property (p_ch3_upper_keep) else $error("ch3 ceiling not kept");

    property p_ch3_lower_keep;
        hit[1] && !lo_ok[1] |=> st.ch3_lim[3:0] == $past(st.ch3_lim[3:0]);
    endproperty
    a_ch3_lower_keep: assert property (p_ch3_lower_keep) else $error("ch3 floor not kept");

    property p_upper_zero_taken;
        hit[1] && req_i.data[7:4] == 4'h0 |=> st.ch3_lim[7:4] == 4'h0;
    endproperty
    a_upper_zero_taken: assert property (p_upper_zero_taken) else $error("widest ceiling refused");

    property p_lower_zero_taken;
        hit[0] && req_i.data[3:0] == 4'h0 && ch2_output_code_i != 8'h00 |=> st.ch2_lim[3:0] == 4'h0;
    endproperty
    a_lower_zero_taken: assert property (p_lower_zero_taken) else $error("widest floor refused");

    property p_reset_values;
        disable iff (1'b0) !rst_n_i |=> st.fast_transient_config == 6'h3f && st.ch3_lim == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_ft_disabled;
        transient_config_pin_i |=> ft_effective_o == 6'h00;
    endproperty
    a_ft_disabled: assert property (p_ft_disabled) else $error("sensitivity active while disabled");

    property p_ft_enabled;
        !transient_config_pin_i |=> ft_effective_o == $past(st.fast_transient_config);
    endproperty
    a_ft_enabled: assert property (p_ft_enabled) else $error("sensitivity not applied");

    property p_ft_read;
        req_i.rd && req_i.addr == `DLF_FAST_TRANSIENT_CONFIG_ADDR && !req_i.wr |=> rd_valid_o && rd_data_o == {2'b00, st.fast_transient_config};
    endproperty
    a_ft_read: assert property (p_ft_read) else $error("bad transient config read");

    property p_code_ok;
        st.ch2_lim == 8'h00 && ch2_output_code_i != 8'h00 |=> code_ok_o[0];
    endproperty
    a_code_ok: assert property (p_code_ok) else $error("code wrongly out of range");

    property p_split_commit;
        hit[1] && up_ok[1] && !lo_ok[1] |=> st.ch3_lim[7:4] == $past(req_i.data[7:4]);
    endproperty
    a_split_commit: assert property (p_split_commit) else $error("passing field not committed");

    c_reject: cover property (hit[0] && !up_ok[0]);
    c_split: cover property (hit[1] && up_ok[1] && !lo_ok[1]);
    c_disable: cover property (transient_config_pin_i && st.fast_transient_config != 6'h00);
endmodule
`default_nettype wire

// ==== dlf_regs.svh ====
// offsets, field positions, reset values and scale constants of the limit and transient registers
`ifndef DLF_REGS_SVH
`define DLF_REGS_SVH
// register offsets
`define DLF_CH2_LIM_ADDR 8'h00dd
`define DLF_CH3_LIM_ADDR 8'h00de
`define DLF_FAST_TRANSIENT_CONFIG_ADDR 8'h00df
// reset values
`define DLF_CH2_LIM_RST 8'h0000
`define DLF_CH3_LIM_RST 8'h0000
`define DLF_FAST_TRANSIENT_CONFIG_RST 6'h003f
// limit field positions
`define DLF_UPPER_MSB 7
`define DLF_UPPER_LSB 4
`define DLF_LOWER_MSB 3
`define DLF_LOWER_LSB 0
// voltage scale in half-millivolt units
`define DLF_VREF_TRIM_HALF 12'h04b0
`define DLF_UPPER_OFS_HALF 12'h0180
`define DLF_LOWER_OFS_HALF 12'h017d
`define DLF_LIMIT_STEP_HALF 12'h0018
`define DLF_CODE_BASE_HALF 12'h0330
`define DLF_CODE_STEP_HALF 12'h0003
`endif

// ==== dlf_pkg.sv ====
// types shared by the limit and transient register logic
package dlf_pkg;
    // decoded register request from the two-wire engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } dlf_req_t;

    // sensitivity field encoding
    typedef enum logic [1:0] {
        DLF_FT_OFF = 2'b00,
        DLF_FT_NARROW_X3 = 2'b01,
        DLF_FT_NARROW_X5 = 2'b10,
        DLF_FT_WIDE_X5 = 2'b11
    } dlf_sens_t;

    // whole state of the register bank
    typedef struct packed {
        logic [7:0] ch2_lim;
        logic [7:0] ch3_lim;
        logic [5:0] fast_transient_config;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_rejected;
        logic [5:0] ft_effective;
        logic [1:0] code_ok;
    } dlf_state_t;
endpackage

// ==== dlf_limit_check.sv ====
// one channel's limit checks against its present output code
`timescale 1ns/1ps
`default_nettype none
`include "dlf_regs.svh"
module dlf_limit_check
    import dlf_pkg::*;
(
    input wire logic [7:0] code_i,
    input wire logic [7:0] cur_lim_i,
    input wire logic [7:0] new_lim_i,
    output logic upper_ok_o,
    output logic lower_ok_o,
    output logic in_range_o
);
    logic [11:0] code_v; // present output voltage
    logic [11:0] new_up_v; // candidate ceiling
    logic [11:0] new_lo_v; // candidate floor
    logic [11:0] cur_up_v; // stored ceiling
    logic [11:0] cur_lo_v; // stored floor

    // voltage of a ceiling code
    function automatic logic [11:0] up_v(input logic [3:0] c);
        up_v = 12'(`DLF_VREF_TRIM_HALF + `DLF_UPPER_OFS_HALF - `DLF_LIMIT_STEP_HALF * {8'h00, c});
    endfunction

    // voltage of a floor code
    function automatic logic [11:0] lo_v(input logic [3:0] c);
        lo_v = 12'(`DLF_VREF_TRIM_HALF - `DLF_LOWER_OFS_HALF + `DLF_LIMIT_STEP_HALF * {8'h00, c});
    endfunction

    // all values in half-millivolt units so 190.5 mV stays exact
    always_comb begin
        code_v = 12'(`DLF_CODE_BASE_HALF + `DLF_CODE_STEP_HALF * {4'h0, code_i});
        new_up_v = up_v(new_lim_i[`DLF_UPPER_MSB:`DLF_UPPER_LSB]);
        new_lo_v = lo_v(new_lim_i[`DLF_LOWER_MSB:`DLF_LOWER_LSB]);
        cur_up_v = up_v(cur_lim_i[`DLF_UPPER_MSB:`DLF_UPPER_LSB]);
        cur_lo_v = lo_v(cur_lim_i[`DLF_LOWER_MSB:`DLF_LOWER_LSB]);
        upper_ok_o = (new_up_v >= code_v);
        lower_ok_o = (new_lo_v <= code_v);
        in_range_o = (cur_lo_v <= code_v) && (code_v <= cur_up_v);
    end
endmodule
`default_nettype wire

// ==== dlf_host_model.sv ====
// host model that issues decoded register accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module dlf_host_model
    import dlf_pkg::*;
(
    input wire logic clock_i,
    output var dlf_req_t req_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    // idle bus: no strobe raised
    initial begin
        req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, data: 8'h00};
    end

    // one access: held across one taken edge, answer sampled after it
    task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic v);
        @(posedge clock_i);
        #1;
        req_o = '{wr: w, rd: r, addr: a, data: d};
        @(posedge clock_i);
        #1;
        q = rd_data_i;
        v = rd_valid_i;
        // released lines show the inverse so stale values never pass for live ones
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule
`default_nettype wire

// ==== test_dlf_regs_top.sv ====
// self-checking bench for the limit and fast-transient register bank
`timescale 1ns/1ps
`default_nettype none
module test_dlf_regs_top
    import dlf_pkg::*;
;
    logic clock_i; // bench clock
    logic rst_n_i; // synchronous reset, active low
    dlf_req_t req; // host request
    logic [7:0] code2, code3, rd_data, q, lim2, lim3, d;
    logic rd_valid, rej, v, pin;
    logic [5:0] ft_eff;
    logic [1:0] code_ok;
    int fails, checks, cycles;
    logic [7:0] codes [3] = '{8'h80, 8'hff, 8'h00}; // mid, top and bottom codes
    logic [7:0] datas [4] = '{8'h00, 8'hff, 8'h0f, 8'hf0}; // limit field corners

    dlf_host_model i_host (.clock_i(clock_i), .req_o(req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
    dlf_regs_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .ch2_output_code_i(code2),
        .ch3_output_code_i(code3), .transient_config_pin_i(pin), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .wr_rejected_o(rej), .ft_effective_o(ft_eff), .code_ok_o(code_ok));

    // clock at 40 ns period
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // ceiling voltage in half millivolts reaches the code voltage
    function automatic logic ceil_ok(input logic [7:0] c, input logic [3:0] u);
        return (12'h0630 - 12'h0018 * u) >= (12'h0330 + 12'h0003 * c);
    endfunction

    // floor voltage does not exceed the code voltage
    function automatic logic floor_ok(input logic [7:0] c, input logic [3:0] l);
        return (12'h0333 + 12'h0018 * l) <= (12'h0330 + 12'h0003 * c);
    endfunction

    // model one field-wise checked limit write
    function automatic logic [7:0] merge(input logic [7:0] c, input logic [7:0] old, input logic [7:0] n);
        return {ceil_ok(c, n[7:4]) ? n[7:4] : old[7:4], floor_ok(c, n[3:0]) ? n[3:0] : old[3:0]};
    endfunction

    // reject flag: either field failing counts, even when the kept field equals the written one
    function automatic logic refused(input logic [7:0] c, input logic [7:0] n);
        return !(ceil_ok(c, n[7:4]) && floor_ok(c, n[3:0]));
    endfunction

    // register write, then the reject pulse of the same answer cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic exp_rej);
        i_host.access(1'b1, 1'b0, a, dat, q, v);
        check("wr_rejected", {7'h00, rej}, {7'h00, exp_rej});
    endtask

    // register read with data compare
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_host.access(1'b0, 1'b1, a, 8'h00, q, v);
        check("rd_valid", {7'h00, v}, 8'h01);
        check("rd_data", q, exp);
    endtask

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        code2 = 8'h80;
        code3 = 8'h80;
        pin = 1'b0;
        lim2 = 8'h00;
        lim3 = 8'h00;
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        rd(8'hdd, 8'h00);
        rd(8'hde, 8'h00);
        rd(8'hdf, 8'h3f);
        rd(8'he0, 8'h00);
        // limit writes across codes and field corners, both channels
        foreach (codes[k]) begin
            foreach (datas[j]) begin
                code2 = codes[k];
                code3 = ~codes[k];
                d = merge(code2, lim2, datas[j]);
                wr(8'hdd, datas[j], refused(code2, datas[j]));
                lim2 = d;
                d = merge(code3, lim3, datas[j]);
                wr(8'hde, datas[j], refused(code3, datas[j]));
                lim3 = d;
                rd(8'hdd, lim2);
                rd(8'hde, lim3);
                check("code_ok", {6'h00, code_ok}, {6'h00, floor_ok(code3, lim3[3:0]) && ceil_ok(code3, lim3[7:4]),
                    floor_ok(code2, lim2[3:0]) && ceil_ok(code2, lim2[7:4])});
            end
        end
        // every sensitivity code in every field, pin enabling and disabling
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                pin = p[0];
                d = {2'b11, s[1:0], s[1:0], s[1:0]};
                wr(8'hdf, d, 1'b0);
                rd(8'hdf, {2'b00, d[5:0]});
                check("ft_effective", {2'b00, ft_eff}, pin ? 8'h00 : {2'b00, d[5:0]});
            end
        end
        // unmapped write reads back zero and leaves the ch2 limit alone
        wr(8'he0, 8'hff, 1'b0);
        rd(8'he0, 8'h00);
        rd(8'hdd, lim2);
        stop_test();
    end
endmodule
`default_nettype wire
